// ---- design/cstm_timer.sv ----
// clock select and interval timer top level
// assumes oscillator inputs are levels sampled by ref_clk_in, well below it
// Functional notes
// RL1: mode bits 2..0 pick the count pulse from sys/256, cnt/64, cnt, sys/32, cnt/8.
// RL2: mode bit 3 set routes the timer output onto the shared pin, clear withholds it.
// RL3: mode bit 0 picks the display clock, sys/256 at 0 and cnt/64 at 1.
// RL4: a port write instruction addressing the mode register loads it from the data.
// RL5: the count register is an 8-bit up-counter stepping on each count pulse.
// RL6: the count clears on the start instruction, on reset, or on a limit match.
// RL7: the limit register holds the maximum count, loads by instruction, resets to ff.
// RL8: the match interrupt is raised one count pulse after equality is seen.
// RL9: the cpu phase clock is the system oscillator output halved.
// RL10: stop mode on the rc oscillator stops both the oscillator output and cpu clock.
// RL11: halt mode stops only the halved cpu clock and keeps the oscillator output.
// RL12: with an external system clock both standby modes stop only the halver.
// RL13: the count oscillator output keeps running in every standby mode.
// RL14: reset clears the mode register and prescalers, giving sys/256 and no pin drive.
// RL15: reset sets count 00, limit ff and the timer output flip-flop 0.
// RL16: the timer flip-flop toggles on each match to form the timer output.
// RL17: software never writes the prohibited count codes 110 and 111.
`timescale 1ns/100ps
`include "cstm_params.svh"
module cstm_timer
	import cstm_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic sys_osc_in,
	input wire logic crystal_in,
	input wire logic ext_clock_mode_in,
	input wire logic stop_mode_in,
	input wire logic halt_mode_in,
	input wire cstm_cmd_t cmd_in,
	output logic system_osc_out,
	output logic cpu_phase_clk_out,
	output logic count_osc_out,
	output logic count_pulse_out,
	output logic display_clock_out,
	output logic timer_out_signal_out,
	output logic timer_output_pin_out,
	output logic timer_output_pin_oe_n_out,
	output logic timer_match_irq_out,
	output logic [7:0] timer_count_out,
	output logic [3:0] clock_mode_out
);
	cstm_mode_t mode_r;
	logic [7:0] count_r;
	logic [7:0] limit_r;
	logic tff_r;
	logic irq_r;
	logic match_pend_r;
	logic sys_prev_r;
	logic cnt_prev_r;
	logic half_r;
	logic sys_osc_r;
	logic cnt_osc_r;
	logic sys_gate;
	logic sys_edge;
	logic cnt_edge;
	logic sys256_tick;
	logic sys32_tick;
	logic cnt64_tick;
	logic cnt8_tick;
	logic count_pulse;
	logic disp_nxt;
	logic disp_r;
	logic match;

	// rc oscillator halts in stop mode; an external clock keeps passing
	assign sys_gate = ext_clock_mode_in || !stop_mode_in; // see RL10 see RL12

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sys_osc_r <= 1'b0;
			cnt_osc_r <= 1'b0;
			sys_prev_r <= 1'b0;
			cnt_prev_r <= 1'b0;
		end else begin
			sys_osc_r <= sys_gate ? sys_osc_in : sys_osc_r; // see RL11
			cnt_osc_r <= crystal_in; // see RL13
			sys_prev_r <= sys_osc_r;
			cnt_prev_r <= cnt_osc_r;
		end
	end
	assign sys_edge = sys_osc_r && !sys_prev_r;
	assign cnt_edge = cnt_osc_r && !cnt_prev_r;
	assign system_osc_out = sys_osc_r;
	assign count_osc_out = cnt_osc_r;

	// halver stops in either standby mode
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			half_r <= 1'b0;
		end else if (sys_edge && !stop_mode_in && !halt_mode_in) begin
			half_r <= !half_r; // see RL9 see RL10 see RL11 see RL12
		end
	end
	assign cpu_phase_clk_out = half_r;

	// separate prescalers per ratio; reset clears all of them
	cstm_prescale #(.DIV(`CSTM_SYS_DIV_LONG)) u_sys256 ( // see RL14
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.step_in(sys_edge),
		.tick_out(sys256_tick)
	);
	cstm_prescale #(.DIV(`CSTM_SYS_DIV_SHORT)) u_sys32 (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.step_in(sys_edge),
		.tick_out(sys32_tick)
	);
	cstm_prescale #(.DIV(`CSTM_CNT_DIV_LONG)) u_cnt64 (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.step_in(cnt_edge),
		.tick_out(cnt64_tick)
	);
	cstm_prescale #(.DIV(`CSTM_CNT_DIV_SHORT)) u_cnt8 (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.step_in(cnt_edge),
		.tick_out(cnt8_tick)
	);

	// prohibited codes give no pulse at all, so counting simply freezes
	always_comb begin
		unique case (mode_r.count_source_sel) // see RL1 see RL17
			CSTM_SRC_SYS256: count_pulse = sys256_tick;
			CSTM_SRC_CNT64: count_pulse = cnt64_tick;
			CSTM_SRC_CNT_A: count_pulse = cnt_edge;
			CSTM_SRC_CNT_B: count_pulse = cnt_edge;
			CSTM_SRC_SYS32: count_pulse = sys32_tick;
			CSTM_SRC_CNT8: count_pulse = cnt8_tick;
			default: count_pulse = 1'b0;
		endcase
	end
	assign count_pulse_out = count_pulse;

	// display clock is the selected tick, one pulse per division;
	// a toggled level would halve the required rate
	always_comb begin
		disp_nxt = sys256_tick;
		if (mode_r[`CSTM_BIT_DISP_SEL]) begin
			disp_nxt = cnt64_tick; // see RL3
		end
	end
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			disp_r <= 1'b0;
		end else begin
			disp_r <= disp_nxt;
		end
	end
	assign display_clock_out = disp_r;

	// mode register load
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mode_r <= `CSTM_MODE_RST; // see RL14
		end else if (cmd_in.port_write_instr &&
			cmd_in.port_addr == `CSTM_PORT_CLK_MODE) begin
			mode_r <= cmd_in.data[3:0]; // see RL4
		end
	end
	assign clock_mode_out = mode_r;

	// limit register load
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			limit_r <= `CSTM_LIMIT_RST; // see RL15
		end else if (cmd_in.limit_load_instr) begin
			limit_r <= cmd_in.data; // see RL7
		end
	end

	assign match = (count_r == limit_r);

	// equality arms a pending match; the next pulse clears and signals
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			count_r <= `CSTM_COUNT_RST; // see RL15
			match_pend_r <= 1'b0;
		end else if (cmd_in.timer_start) begin
			count_r <= `CSTM_COUNT_RST; // see RL6
			match_pend_r <= 1'b0;
		end else if (count_pulse) begin
			if (match_pend_r) begin
				count_r <= `CSTM_COUNT_RST; // see RL6
				match_pend_r <= 1'b0;
			end else begin
				count_r <= count_r + 8'h01; // see RL5
				match_pend_r <= (count_r + 8'h01) == limit_r;
			end
		end else begin
			match_pend_r <= match;
		end
	end
	assign timer_count_out = count_r;

	// interrupt pulse and timer flip-flop at the pulse after equality
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_r <= 1'b0;
			tff_r <= 1'b0;
		end else begin
			irq_r <= count_pulse && match_pend_r && !cmd_in.timer_start;
			if (count_pulse && match_pend_r && !cmd_in.timer_start) begin
				tff_r <= !tff_r; // see RL8 see RL16
			end
		end
	end
	assign timer_match_irq_out = irq_r;
	assign timer_out_signal_out = tff_r;

	// pin enable is low-active; pin data stays low while withheld
	assign timer_output_pin_out = mode_r.timer_pin_enable & tff_r; // see RL2
	assign timer_output_pin_oe_n_out = !mode_r.timer_pin_enable; // see RL2

	// a match fires on the first pulse after equality was armed
	sequence fire_s;
		count_pulse && match_pend_r && !cmd_in.timer_start;
	endsequence
	// the cycle after firing shows the interrupt and a cleared count
	sequence wrap_s;
		timer_match_irq_out && count_r == 8'h00;
	endsequence

	irq_delay_a: assert property (@(posedge ref_clk_in) // see RL8
		disable iff (sys_rst_in)
		fire_s |=> timer_match_irq_out)
		else $error("match irq not raised after pulse");
	match_wrap_a: assert property (@(posedge ref_clk_in) // see RL6
		disable iff (sys_rst_in)
		fire_s |=> wrap_s)
		else $error("count not cleared on match");
	irq_cause_a: assert property (@(posedge ref_clk_in) // see RL8
		disable iff (sys_rst_in)
		timer_match_irq_out |->
		$past(count_pulse && match_pend_r && !cmd_in.timer_start))
		else $error("match irq without armed pulse");
	count_clear_a: assert property (@(posedge ref_clk_in) // see RL6
		disable iff (sys_rst_in)
		cmd_in.timer_start |=> count_r == 8'h00)
		else $error("count not cleared by start");
	count_step_a: assert property (@(posedge ref_clk_in) // see RL5
		disable iff (sys_rst_in)
		(count_pulse && !match_pend_r && !cmd_in.timer_start)
		|=> count_r == $past(count_r) + 8'h01)
		else $error("count did not step");
	count_hold_a: assert property (@(posedge ref_clk_in) // see RL5
		disable iff (sys_rst_in)
		(!count_pulse && !cmd_in.timer_start) |=> $stable(count_r))
		else $error("count moved without pulse");
	tff_toggle_a: assert property (@(posedge ref_clk_in) // see RL16
		disable iff (sys_rst_in)
		timer_match_irq_out |-> tff_r != $past(tff_r))
		else $error("timer flip-flop not toggled");
	mode_load_a: assert property (@(posedge ref_clk_in) // see RL4
		disable iff (sys_rst_in)
		(cmd_in.port_write_instr && cmd_in.port_addr == `CSTM_PORT_CLK_MODE)
		|=> clock_mode_out == $past(cmd_in.data[3:0]))
		else $error("mode register not loaded");
	limit_load_a: assert property (@(posedge ref_clk_in) // see RL7
		disable iff (sys_rst_in)
		cmd_in.limit_load_instr |=> limit_r == $past(cmd_in.data))
		else $error("limit register not loaded");
	pin_gate_a: assert property (@(posedge ref_clk_in) // see RL2
		disable iff (sys_rst_in)
		!mode_r.timer_pin_enable |-> timer_output_pin_oe_n_out)
		else $error("pin driven while disabled");
	pin_drive_a: assert property (@(posedge ref_clk_in) // see RL2
		disable iff (sys_rst_in)
		mode_r.timer_pin_enable |->
		(!timer_output_pin_oe_n_out && timer_output_pin_out == tff_r))
		else $error("pin not driven while enabled");
	disp_pick_a: assert property (@(posedge ref_clk_in) // see RL3
		disable iff (sys_rst_in)
		mode_r[`CSTM_BIT_DISP_SEL] |=> display_clock_out == $past(cnt64_tick))
		else $error("display clock not from count clock");
	cpu_run_a: assert property (@(posedge ref_clk_in) // see RL9
		disable iff (sys_rst_in)
		(sys_edge && !stop_mode_in && !halt_mode_in)
		|=> cpu_phase_clk_out != $past(cpu_phase_clk_out))
		else $error("cpu clock did not halve");
	halt_cpu_a: assert property (@(posedge ref_clk_in) // see RL11
		disable iff (sys_rst_in)
		(halt_mode_in || stop_mode_in) |=> $stable(cpu_phase_clk_out))
		else $error("cpu clock ran in standby");
	stop_osc_a: assert property (@(posedge ref_clk_in) // see RL10
		disable iff (sys_rst_in)
		(stop_mode_in && !ext_clock_mode_in) |=> $stable(system_osc_out))
		else $error("rc oscillator ran in stop");
	halt_osc_a: assert property (@(posedge ref_clk_in) // see RL11
		disable iff (sys_rst_in)
		(halt_mode_in && !stop_mode_in)
		|=> system_osc_out == $past(sys_osc_in))
		else $error("oscillator stopped in halt");
	ext_osc_a: assert property (@(posedge ref_clk_in) // see RL12
		disable iff (sys_rst_in)
		ext_clock_mode_in |=> system_osc_out == $past(sys_osc_in))
		else $error("external clock not passed");
	cnt_run_a: assert property (@(posedge ref_clk_in) // see RL13
		disable iff (sys_rst_in)
		##1 count_osc_out == $past(crystal_in))
		else $error("count oscillator stalled");
	prohib_a: assert property (@(posedge ref_clk_in) // see RL17
		disable iff (sys_rst_in)
		mode_r[2:1] == 2'b11 |-> !count_pulse)
		else $error("pulse under prohibited code");
endmodule

// ---- design/cstm_params.svh ----
// constants for the clock select and interval timer
// assumes inclusion from design modules by bare name
`ifndef CSTM_PARAMS_SVH
`define CSTM_PARAMS_SVH
`define CSTM_PORT_CLK_MODE 4'h0
`define CSTM_PORT_LIMIT 4'h1
`define CSTM_MODE_RST 4'h0
`define CSTM_COUNT_RST 8'h00
`define CSTM_LIMIT_RST 8'hff
`define CSTM_BIT_PIN_EN 3
`define CSTM_BIT_DISP_SEL 0
`define CSTM_SYS_DIV_LONG 256
`define CSTM_SYS_DIV_SHORT 32
`define CSTM_CNT_DIV_LONG 64
`define CSTM_CNT_DIV_SHORT 8
`endif

// ---- design/cstm_pkg.sv ----
// types shared by the clock select and interval timer
// assumes cstm_params.svh is reachable by bare name
package cstm_pkg;
	typedef enum logic [2:0] {
		CSTM_SRC_SYS256 = 3'b000,
		CSTM_SRC_CNT64 = 3'b001,
		CSTM_SRC_CNT_A = 3'b010,
		CSTM_SRC_CNT_B = 3'b011,
		CSTM_SRC_SYS32 = 3'b100,
		CSTM_SRC_CNT8 = 3'b101,
		CSTM_SRC_BAD_A = 3'b110,
		CSTM_SRC_BAD_B = 3'b111
	} cstm_src_t;
	typedef struct packed {
		logic timer_pin_enable;
		cstm_src_t count_source_sel;
	} cstm_mode_t;
	typedef struct packed {
		logic port_write_instr;
		logic limit_load_instr;
		logic timer_start;
		logic [3:0] port_addr;
		logic [7:0] data;
	} cstm_cmd_t;
endpackage

// ---- design/cstm_prescale.sv ----
// free-running prescaler producing a one-cycle tick per division
// assumes an enable pulse per source clock edge, synchronous to ref clock
`timescale 1ns/100ps
`include "cstm_params.svh"
module cstm_prescale #(
	parameter int DIV = 256
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic step_in,
	output logic tick_out
);
	localparam int W = $clog2(DIV);
	logic [W-1:0] cnt_r;
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_r <= '0;
		end else if (step_in) begin
			cnt_r <= (cnt_r == W'(DIV - 1)) ? '0 : cnt_r + W'(1);
		end
	end
	assign tick_out = step_in && (cnt_r == W'(DIV - 1));
endmodule

// ---- bench/cstm_timer_test.sv ----
// self-checking bench for the clock select and interval timer
// assumes design files compile first; bench drives every port itself
`timescale 1ns/100ps
module cstm_timer_test;
	import cstm_pkg::*;
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic sys_osc = 1'b0;
	logic xtal = 1'b0;
	logic ext_m = 1'b0;
	logic stop_m = 1'b0;
	logic halt_m = 1'b0;
	cstm_cmd_t cmd = '0;
	logic so, cpu, co, cp, dc, timer_out_signal, pin, oe_n, irq;
	logic [7:0] cnt;
	logic [3:0] mode;
	logic [7:0] lim;
	logic [31:0] rs = 32'h3a902253;
	logic t0;
	int miscompares = 0;
	int comparisons = 0;
	int irqs = 0;
	int cps = 0;
	int dcs = 0;
	int expv = 0;
	int dv [5] = '{256, 64, 32, 8, 1};
	logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h3};
	bit xt [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	always #12.5 ref_clk_in = ~ref_clk_in;
	// one-cycle pulses are counted here rather than polled
	always @(posedge ref_clk_in) begin
		if (irq === 1'b1) irqs <= irqs + 1;
		if (cp === 1'b1) cps <= cps + 1;
		if (dc === 1'b1) dcs <= dcs + 1;
	end

	cstm_timer uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.sys_osc_in(sys_osc), .crystal_in(xtal), .ext_clock_mode_in(ext_m),
		.stop_mode_in(stop_m), .halt_mode_in(halt_m), .cmd_in(cmd),
		.system_osc_out(so), .cpu_phase_clk_out(cpu), .count_osc_out(co),
		.count_pulse_out(cp), .display_clock_out(dc),
		.timer_out_signal_out(timer_out_signal), .timer_output_pin_out(pin),
		.timer_output_pin_oe_n_out(oe_n), .timer_match_irq_out(irq),
		.timer_count_out(cnt), .clock_mode_out(mode));

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task automatic test_done;
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task automatic op(input logic w, input logic l, input logic s,
		input logic [3:0] a, input logic [7:0] d);
		cmd = '{w, l, s, a, d};
		tick(1);
		cmd = '0;
		// idle edge so back-to-back commands never share a time step
		tick(1);
	endtask

	// six cycles per source period keeps edges well below ref_clk/2
	task automatic edges(input bit on_xtal, input int n);
		repeat (n) begin
			xtal = on_xtal;
			sys_osc = !on_xtal;
			tick(3);
			xtal = 1'b0;
			sys_osc = 1'b0;
			tick(3);
		end
	endtask

	initial begin
		tick(4);
		sys_rst_in = 1'b0;
		chk(8'(mode), 8'h00);
		chk(cnt, 8'h00);
		chk(8'({oe_n, timer_out_signal, irq}), 8'h04);
		op(1'b1, 1'b0, 1'b0, 4'h0, 8'h02);
		chk(8'(mode), 8'h02);
		edges(1'b1, 255);
		chk(cnt, 8'hff);
		edges(1'b1, 1);
		chk(cnt, 8'h00);
		chk(8'(irqs), 8'h01);
		chk(8'(timer_out_signal), 8'h01);
		rs = xs(rs);
		lim = 8'(rs[1:0]) + 8'h01;
		op(1'b0, 1'b1, 1'b0, 4'h0, lim);
		op(1'b1, 1'b0, 1'b0, 4'h0, 8'h0a);
		chk(8'({oe_n, pin}), 8'h01);
		op(1'b1, 1'b0, 1'b0, rs[7:4] | 4'h1, rs[15:8]);
		chk(8'(mode), 8'h0a);
		op(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
		chk(cnt, 8'h00);
		expv = 0;
		for (int i = 0; i <= int'(lim); i++) begin
			edges(1'b1, 1);
			expv = (expv == int'(lim)) ? 0 : expv + 1;
			chk(cnt, 8'(expv));
		end
		chk(8'(irqs), 8'h02);
		chk(8'({oe_n, pin, timer_out_signal}), 8'h00);
		op(1'b1, 1'b0, 1'b0, 4'h0, 8'h02);
		chk(8'(oe_n), 8'h01);
		op(1'b0, 1'b1, 1'b0, 4'h0, 8'hff);
		// prescalers run free, yet 2*div edges always give two pulses
		for (int k = 0; k < 5; k++) begin
			op(1'b1, 1'b0, 1'b0, 4'h0, 8'(cd[k]));
			op(1'b0, 1'b0, 1'b1, 4'h0, 8'h00);
			expv = cps;
			edges(xt[k], 2 * dv[k]);
			chk(cnt, 8'h02);
			chk(8'(cps - expv), 8'h02);
		end
		expv = dcs;
		edges(1'b1, 64);
		chk(8'(dcs - expv), 8'h01);
		op(1'b1, 1'b0, 1'b0, 4'h0, 8'h00);
		expv = dcs;
		edges(1'b0, 256);
		chk(8'(dcs - expv), 8'h01);
		t0 = cpu;
		edges(1'b0, 1);
		chk(8'(cpu), 8'({~t0}));
		stop_m = 1'b1;
		sys_osc = 1'b1;
		xtal = 1'b1;
		tick(3);
		chk(8'({so, cpu, co}), 8'({1'b0, ~t0, 1'b1}));
		stop_m = 1'b0;
		halt_m = 1'b1;
		tick(3);
		chk(8'({so, cpu}), 8'({1'b1, ~t0}));
		halt_m = 1'b0;
		stop_m = 1'b1;
		ext_m = 1'b1;
		sys_osc = 1'b0;
		tick(3);
		sys_osc = 1'b1;
		tick(3);
		chk(8'({so, cpu}), 8'({1'b1, ~t0}));
		test_done;
	end

	// whole run is near 7.9k cycles; this cuts off a hang well after
	initial begin
		#1000000;
		miscompares++;
		test_done;
	end
endmodule
